// ==== core/operating_mode_control.sv ====
// Run, active background and wait mode controller with pin overrides
`timescale 1ns/10ps

// Overview of operation
// - Mode-select pin high at reset release selects run mode.
// - Run after reset starts by fetching the vector at FFFE:FFFF.
// - Mode-select pin held low at reset release selects background mode.
// - Background command over the debug pin enters background mode.
// - The debug halt instruction enters background mode.
// - Breakpoint from either debug unit enters background mode.
// - In background mode the processor is suspended, awaiting commands.
// - Non-intrusive commands are accepted in run and background modes.
// - CPU register, trace and resume commands run only in background mode.
// - The wait instruction enters wait mode.
// - Wait stops the processor clock; system clocks and regulation stay.
// - Entering wait clears the interrupt mask bit.
// - An interrupt ends wait and starts the stacking sequence.
// - In wait only background and status-memory commands are accepted.
// - Status-memory commands in wait skip access, report stop/wait error.
// - Background command in wait wakes into background mode.
// - Debug function enabled forces mode pin pull-up on, slew off.
// - Crystal function disables pull-up and slew on crystal pins.
// - Serial 2 function sets its pins to partial drive strength.
module operating_mode_control (
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         debug_mode_select_pin,
	input  wire logic                         debug_halt_instruction,
	input  wire logic                         wait_instruction,
	input  wire logic                         ctrl_breakpoint,
	input  wire logic                         icd_breakpoint,
	input  wire logic                         irq_request,
	input  wire logic                         cmd_valid,
	input  wire logic [opmode_pkg::CMD_W-1:0] cmd_code,
	input  wire logic                         background_debug_function,
	input  wire logic                         crystal_function,
	input  wire logic                         serial2_function,
	input  wire logic                         sw_pullup_mode_pin,
	input  wire logic                         sw_slew_mode_pin,
	input  wire logic [1:0]                   sw_pullup_crystal,
	input  wire logic [1:0]                   sw_slew_crystal,
	input  wire logic [1:0]                   sw_full_drive_serial2,
	output logic                              mode_run,
	output logic                              mode_background,
	output logic                              mode_wait,
	output logic                              cpu_exec_en,
	output logic                              cpu_clk_en,
	output logic                              system_clk_en,
	output logic                              regulator_full,
	output logic                              fetch_reset_vector,
	output logic [15:0]                       vector_addr_hi,
	output logic [15:0]                       vector_addr_lo,
	output logic                              clear_irq_mask,
	output logic                              start_irq_stacking,
	output logic                              cmd_accept,
	output logic                              cmd_refused,
	output logic                              cmd_no_mem_access,
	output logic [1:0]                        cmd_status,
	output logic                              mode_pin_pullup_en,
	output logic                              mode_pin_slew_en,
	output logic [1:0]                        crystal_pullup_en,
	output logic [1:0]                        crystal_slew_en,
	output logic [1:0]                        serial2_full_drive
);
	import opmode_pkg::*;

	// ****************************************
	// Mode strap capture
	// ****************************************
	logic strap_valid;
	logic strap_run;

	mode_strap_latch u_strap (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.pin_level   (debug_mode_select_pin),
		.strap_valid (strap_valid),
		.strap_run   (strap_run)
	);

	// ****************************************
	// Command gating
	// ****************************************
	op_mode_t mode_q, mode_d;
	logic     gate_accept;
	logic     gate_no_mem;
	logic [1:0] gate_status;

	cmd_gate u_gate (
		.in_run        (mode_q == MODE_RUN),
		.in_bkg        (mode_q == MODE_BKG),
		.in_wait       (mode_q == MODE_WAIT),
		.cmd           (cmd_code),
		.accept        (gate_accept),
		.no_mem_access (gate_no_mem),
		.status        (gate_status)
	);

	// ****************************************
	// Mode state machine
	// ****************************************
	logic bkg_cmd;
	logic resume_cmd;
	logic started_q, started_d;
	logic fetch_q, fetch_d;
	logic clr_mask_q, clr_mask_d;
	logic stack_q, stack_d;
	logic accept_q, accept_d;
	logic refused_q, refused_d;
	logic nomem_q, nomem_d;
	logic [1:0] status_q, status_d;

	assign bkg_cmd    = cmd_valid && gate_accept && cmd_code == CMD_BACKGROUND;
	assign resume_cmd = cmd_valid && gate_accept && cmd_code == CMD_RESUME;

	// Next mode and one-cycle event pulses
	always_comb begin
		mode_d        = mode_q;
		started_d     = started_q;
		fetch_d       = 1'b0;
		clr_mask_d    = 1'b0;
		stack_d       = 1'b0;
		accept_d      = cmd_valid && gate_accept;
		refused_d     = cmd_valid && !gate_accept;
		nomem_d       = cmd_valid && gate_no_mem;
		status_d      = cmd_valid ? gate_status : STAT_OK;
		if (strap_valid && !started_q) begin
			started_d = 1'b1;
			if (strap_run) begin
				mode_d  = MODE_RUN;
				fetch_d = 1'b1;
			end else begin
				mode_d = MODE_BKG;
			end
		end else if (started_q) begin
			case (mode_q)
				MODE_RUN: begin
					if (bkg_cmd || debug_halt_instruction ||
						ctrl_breakpoint || icd_breakpoint) begin
						mode_d = MODE_BKG;
					end else if (wait_instruction) begin
						mode_d     = MODE_WAIT;
						clr_mask_d = 1'b1;
					end
				end
				MODE_BKG: begin
					if (resume_cmd) begin
						mode_d = MODE_RUN;
					end
				end
				MODE_WAIT: begin
					if (bkg_cmd) begin
						mode_d = MODE_BKG;
					end else if (irq_request) begin
						mode_d  = MODE_RUN;
						stack_d = 1'b1;
					end
				end
				default: mode_d = MODE_BKG;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_q     <= MODE_BKG;
			started_q  <= 1'b0;
			fetch_q    <= 1'b0;
			clr_mask_q <= 1'b0;
			stack_q    <= 1'b0;
			accept_q   <= 1'b0;
			refused_q  <= 1'b0;
			nomem_q    <= 1'b0;
			status_q   <= STAT_OK;
		end else begin
			mode_q     <= mode_d;
			started_q  <= started_d;
			fetch_q    <= fetch_d;
			clr_mask_q <= clr_mask_d;
			stack_q    <= stack_d;
			accept_q   <= accept_d;
			refused_q  <= refused_d;
			nomem_q    <= nomem_d;
			status_q   <= status_d;
		end
	end

	// ****************************************
	// Mode and clock outputs
	// ****************************************
	assign mode_run        = started_q && mode_q == MODE_RUN;
	assign mode_background = started_q && mode_q == MODE_BKG;
	assign mode_wait       = started_q && mode_q == MODE_WAIT;
	assign cpu_exec_en     = mode_run;
	assign cpu_clk_en      = started_q ? !mode_wait : RST_CPU_CLK_EN;
	assign system_clk_en   = 1'b1;
	assign regulator_full  = 1'b1;

	// Event pulses and command answer
	assign fetch_reset_vector = fetch_q;
	assign vector_addr_hi     = RESET_VECTOR_HI_ADDR;
	assign vector_addr_lo     = RESET_VECTOR_LO_ADDR;
	assign clear_irq_mask     = clr_mask_q;
	assign start_irq_stacking = stack_q;
	assign cmd_accept         = accept_q;
	assign cmd_refused        = refused_q;
	assign cmd_no_mem_access  = nomem_q;
	assign cmd_status         = status_q;

	// ****************************************
	// Pin overrides
	// ****************************************
	assign mode_pin_pullup_en = background_debug_function ? 1'b1 :
		sw_pullup_mode_pin;
	assign mode_pin_slew_en   = background_debug_function ? 1'b0 :
		sw_slew_mode_pin;
	assign crystal_pullup_en  = crystal_function ? 2'h0 :
		sw_pullup_crystal;
	assign crystal_slew_en    = crystal_function ? 2'h0 :
		sw_slew_crystal;
	assign serial2_full_drive = serial2_function ? 2'h0 :
		sw_full_drive_serial2;
endmodule // operating_mode_control

// ==== core/opmode_pkg.sv ====
// Constants and types shared by the operating mode controller
package opmode_pkg;

	// ****************************************
	// Reset vector location
	// ****************************************
	localparam logic [15:0] RESET_VECTOR_HI_ADDR = 16'hfffe;
	localparam logic [15:0] RESET_VECTOR_LO_ADDR = 16'hffff;

	// ****************************************
	// Debug command classes
	// ****************************************
	localparam int unsigned CMD_W = 3;
	localparam logic [2:0] CMD_MEM_ACCESS   = 3'h0;
	localparam logic [2:0] CMD_MEM_STATUS   = 3'h1;
	localparam logic [2:0] CMD_CTRL_REG     = 3'h2;
	localparam logic [2:0] CMD_BACKGROUND   = 3'h3;
	localparam logic [2:0] CMD_CPU_REG      = 3'h4;
	localparam logic [2:0] CMD_TRACE        = 3'h5;
	localparam logic [2:0] CMD_RESUME       = 3'h6;

	// ****************************************
	// Command answer status codes
	// ****************************************
	localparam logic [1:0] STAT_OK          = 2'h0;
	localparam logic [1:0] STAT_REFUSED     = 2'h1;
	localparam logic [1:0] STAT_STOP_WAIT   = 2'h2;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic RST_CPU_CLK_EN  = 1'b0;
	localparam logic RST_MODE_BIT    = 1'b1;

	// ****************************************
	// Operating modes, one-hot
	// ****************************************
	typedef enum logic [2:0] {
		MODE_RUN  = 3'b001,
		MODE_BKG  = 3'b010,
		MODE_WAIT = 3'b100
	} op_mode_t;

endpackage

// ==== core/mode_strap_latch.sv ====
// Captures the mode-select pin level once at reset release
`timescale 1ns/10ps
module mode_strap_latch (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic pin_level,
	output logic      strap_valid,
	output logic      strap_run
);
	import opmode_pkg::*;

	logic valid_q, valid_d;
	logic run_q, run_d;

	// Sample once in the first cycle after release
	always_comb begin
		valid_d = valid_q;
		run_d   = run_q;
		if (!valid_q) begin
			valid_d = 1'b1;
			run_d   = pin_level;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			valid_q <= 1'b0;
			run_q   <= RST_MODE_BIT;
		end else begin
			valid_q <= valid_d;
			run_q   <= run_d;
		end
	end

	assign strap_valid = valid_q;
	assign strap_run   = run_q;
endmodule // mode_strap_latch

// ==== core/cmd_gate.sv ====
// Decides whether a debug command may run in the current mode
`timescale 1ns/10ps
module cmd_gate (
	input  wire logic                       in_run,
	input  wire logic                       in_bkg,
	input  wire logic                       in_wait,
	input  wire logic [opmode_pkg::CMD_W-1:0] cmd,
	output logic                            accept,
	output logic                            no_mem_access,
	output logic [1:0]                      status
);
	import opmode_pkg::*;

	// Non-intrusive command class test
	function automatic logic is_nonintrusive(input logic [CMD_W-1:0] c);
		return (c == CMD_MEM_ACCESS) || (c == CMD_MEM_STATUS) ||
			(c == CMD_CTRL_REG) || (c == CMD_BACKGROUND);
	endfunction

	// Mode-dependent acceptance
	always_comb begin
		accept        = 1'b0;
		no_mem_access = 1'b0;
		status        = STAT_REFUSED;
		if (in_wait) begin
			if (cmd == CMD_BACKGROUND) begin
				accept = 1'b1;
				status = STAT_OK;
			end else if (cmd == CMD_MEM_STATUS) begin
				accept        = 1'b1;
				no_mem_access = 1'b1;
				status        = STAT_STOP_WAIT;
			end
		end else if (in_bkg) begin
			if (is_nonintrusive(cmd) || cmd == CMD_CPU_REG ||
				cmd == CMD_TRACE || cmd == CMD_RESUME) begin
				accept = 1'b1;
				status = STAT_OK;
			end
		end else if (in_run && is_nonintrusive(cmd)) begin
			accept = 1'b1;
			status = STAT_OK;
		end
	end
endmodule // cmd_gate

// ==== tb/debug_host_model.sv ====
// Single-wire debug host: strap drive and command issue
`timescale 1ns/10ps
module debug_host_model (
	input  wire logic       clk,
	input  wire logic       hold_low,
	output wire logic       debug_mode_select_pin,
	output logic            cmd_valid,
	output logic [2:0]      cmd_code
);
	// Pin pulled high unless the host holds it low over reset release
	assign debug_mode_select_pin = !hold_low;
	initial {cmd_valid, cmd_code} = 4'h7;
	// Command stands for one taking edge, then the code turns to junk
	task automatic send(input logic [2:0] code);
		{cmd_valid, cmd_code} <= {1'b1, code};
		@(posedge clk);
		{cmd_valid, cmd_code} <= {1'b0, ~code};
	endtask
endmodule // debug_host_model

// ==== tb/opmode_assertions.sv ====
// Checker for mode transitions and debug command answers
`timescale 1ns/10ps
module opmode_assertions (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       debug_mode_select_pin,
	input wire logic       irq_request,
	input wire logic       cmd_valid,
	input wire logic [2:0] cmd_code,
	input wire logic       mode_run,
	input wire logic       mode_background,
	input wire logic       mode_wait,
	input wire logic       cpu_clk_en,
	input wire logic       fetch_reset_vector,
	input wire logic       clear_irq_mask,
	input wire logic       start_irq_stacking,
	input wire logic       cmd_accept,
	input wire logic       cmd_no_mem_access,
	input wire logic [1:0] cmd_status
);
	import opmode_pkg::*;
	logic bkg_cmd;
	// Background entry command taken this cycle
	assign bkg_cmd = cmd_valid && cmd_code == CMD_BACKGROUND;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	one_mode_a: assert property (
		|{mode_run, mode_background, mode_wait}
		|-> $onehot({mode_run, mode_background, mode_wait}))
		else $error("more than one mode active");
	strap_mode_a: assert property (
		$fell(sys_rst) |-> ##2 mode_run == $past(debug_mode_select_pin, 2)
		&& mode_background != $past(debug_mode_select_pin, 2)
		&& fetch_reset_vector == $past(debug_mode_select_pin, 2))
		else $error("mode after reset does not follow strap");
	wait_entry_a: assert property (
		$rose(mode_wait) |-> clear_irq_mask && !cpu_clk_en)
		else $error("wait entry without mask clear or clock stop");
	wait_exit_a: assert property (
		mode_wait && irq_request && !bkg_cmd |=> mode_run && start_irq_stacking)
		else $error("interrupt did not end wait");
	wait_wake_a: assert property (
		mode_wait && bkg_cmd |=> mode_background && cmd_accept)
		else $error("background command did not wake");
	run_refuse_a: assert property (
		mode_run && cmd_valid && cmd_code inside {[CMD_CPU_REG:CMD_RESUME]}
		|=> !cmd_accept && cmd_status == STAT_REFUSED)
		else $error("intrusive command not refused in run");
	nonintrusive_ok_a: assert property (
		(mode_run || mode_background) && cmd_valid && cmd_code <= 3'h3
		|=> cmd_accept && cmd_status == STAT_OK)
		else $error("non-intrusive command not accepted");
	wait_refuse_a: assert property (
		mode_wait && cmd_valid && cmd_code != CMD_MEM_STATUS && !bkg_cmd
		|=> !cmd_accept && cmd_status == STAT_REFUSED)
		else $error("command not refused in wait");
	wait_status_a: assert property (
		mode_wait && cmd_valid && cmd_code == CMD_MEM_STATUS
		|=> cmd_accept && cmd_no_mem_access && cmd_status == STAT_STOP_WAIT)
		else $error("status command in wait not flagged");
endmodule // opmode_assertions
bind operating_mode_control opmode_assertions i_opmode_assertions (.*);

// ==== tb/tb.sv ====
// Self-checking bench for the operating mode controller
`timescale 1ns/10ps
module tb;
	import opmode_pkg::*;
	// Row: code [4:2], accepted in run [1], accepted in wait [0]
	localparam logic [4:0] ROWS [7] = '{5'h02, 5'h07, 5'h0a, 5'h10,
		5'h14, 5'h18, 5'h1c};
	logic        clk, sys_rst, hold_low, wait_instruction, irq_request;
	logic        debug_halt_instruction, ctrl_breakpoint, icd_breakpoint;
	logic        background_debug_function, crystal_function;
	logic        serial2_function, sw_pullup_mode_pin, sw_slew_mode_pin;
	logic [1:0]  sw_pullup_crystal, sw_slew_crystal, sw_full_drive_serial2;
	wire logic   debug_mode_select_pin;
	logic [2:0]  cmd_code;
	logic        cmd_valid, mode_run, mode_background, mode_wait;
	logic        cpu_exec_en, cpu_clk_en, system_clk_en, regulator_full;
	logic        fetch_reset_vector, clear_irq_mask, start_irq_stacking;
	logic        cmd_accept, cmd_refused, cmd_no_mem_access;
	logic        mode_pin_pullup_en, mode_pin_slew_en;
	logic [1:0]  cmd_status, crystal_pullup_en, crystal_slew_en;
	logic [1:0]  serial2_full_drive;
	logic [15:0] vector_addr_hi, vector_addr_lo;
	int          error_cnt, n_compared;
	operating_mode_control i_operating_mode_control (.*);
	debug_host_model i_debug_host_model (.*);
	task automatic tick;
		@(posedge clk);
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One command, answer settled on return
	task automatic cmd(input logic [2:0] code);
		tick;
		i_debug_host_model.send(code);
		#1;
	endtask
	task automatic do_reset(input logic low);
		tick;
		{sys_rst, hold_low} <= {1'b1, low};
		repeat (5) tick;
		sys_rst <= 1'b0;
		repeat (3) tick;
		#1;
	endtask
	// Pulse 0 wait, 1 halt, 2 and 3 breakpoints, 4 interrupt
	task automatic pulse(input int k);
		tick;
		{irq_request, icd_breakpoint, ctrl_breakpoint,
			debug_halt_instruction, wait_instruction} <= 5'(1 << k);
		tick;
		{irq_request, icd_breakpoint, ctrl_breakpoint,
			debug_halt_instruction, wait_instruction} <= 5'h00;
		#1;
	endtask
	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Cut a hang short well past the expected run length
	initial begin
		repeat (2000) tick;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		{sys_rst, hold_low, irq_request, icd_breakpoint} = 4'h8;
		{ctrl_breakpoint, debug_halt_instruction, wait_instruction} = 3'h0;
		{background_debug_function, crystal_function, serial2_function} = 3'h7;
		{sw_pullup_mode_pin, sw_slew_mode_pin, sw_pullup_crystal,
			sw_slew_crystal, sw_full_drive_serial2} = 8'h00;
		{error_cnt, n_compared} = 0;
		do_reset(1'b0);
		check({mode_run, cpu_exec_en, cpu_clk_en}, 3'h7);
		check(vector_addr_hi, RESET_VECTOR_HI_ADDR);
		check(vector_addr_lo, RESET_VECTOR_LO_ADDR);
		// Each code but CMD_BACKGROUND in run, then in wait, then leave wait by interrupt
		foreach (ROWS[i]) begin
			cmd(ROWS[i][4:2]);
			check({cmd_accept, cmd_refused}, {ROWS[i][1], !ROWS[i][1]});
			pulse(0);
			check({mode_wait, clear_irq_mask, cpu_clk_en}, 3'h6);
			check({system_clk_en, regulator_full}, 2'h3);
			cmd(ROWS[i][4:2]);
			check({cmd_accept, cmd_no_mem_access}, {2{ROWS[i][0]}});
			check(cmd_status, ROWS[i][0] ? STAT_STOP_WAIT : STAT_REFUSED);
			pulse(4);
			check({mode_run, start_irq_stacking}, 2'h3);
		end
		// Four ways into background, each left by the resume command
		for (int k = 0; k < 4; k++) begin
			if (k == 0)
				cmd(CMD_BACKGROUND);
			else
				pulse(k);
			check({mode_background, cpu_exec_en}, 2'h2);
			cmd(CMD_CPU_REG);
			check({cmd_accept, mode_background}, 2'h3);
			cmd(CMD_RESUME);
			check({cmd_accept, mode_run}, 2'h3);
		end
		pulse(0);
		cmd(CMD_BACKGROUND);
		check({cmd_accept, mode_background}, 2'h3);
		// Function enables against all-off and all-on software settings
		for (int f = 0; f < 16; f++) begin
			tick;
			{serial2_function, crystal_function,
				background_debug_function} <= f[2:0];
			{sw_pullup_mode_pin, sw_slew_mode_pin, sw_pullup_crystal,
				sw_slew_crystal, sw_full_drive_serial2} <= {8{f[3]}};
			#1;
			check({mode_pin_pullup_en, mode_pin_slew_en},
				{f[0] | f[3], !f[0] & f[3]});
			check({crystal_pullup_en, crystal_slew_en}, {4{!f[1] & f[3]}});
			check(serial2_full_drive, {2{!f[2] & f[3]}});
		end
		do_reset(1'b1);
		check({mode_background, cpu_exec_en, mode_run}, 3'h4);
		tick;
		hold_low <= 1'b0;
		repeat (3) tick;
		#1;
		check(mode_background, 1'b1);
		tally_and_finish();
	end
endmodule // tb
